// ===== aoot_map.vh
// Register offsets, field layouts and reset values for the overrange block.
`ifndef AOOT_MAP_VH
`define AOOT_MAP_VH
`define AOOT_OFF_THR 12'h000
`define AOOT_OFF_PLEN 12'h004
`define AOOT_OFF_MODE 12'h008
`define AOOT_OFF_STAT 12'h00c
// Trim registers are word indices; each byte address is four times one.
`define AOOT_IDX_OADJ_A_DUAL_A 10'h344
`define AOOT_IDX_OADJ_A_DUAL_B 10'h345
`define AOOT_IDX_OADJ_A_SNGL_A 10'h346
`define AOOT_IDX_OADJ_A_SNGL_B 10'h347
`define AOOT_IDX_OADJ_B_A 10'h348
`define AOOT_IDX_OADJ_B_B 10'h349
`define AOOT_IDX_OADJ_CTRL 10'h34a
`define AOOT_OFF_OADJ_A_DUAL_A {`AOOT_IDX_OADJ_A_DUAL_A, 2'b00}
`define AOOT_OFF_OADJ_A_DUAL_B {`AOOT_IDX_OADJ_A_DUAL_B, 2'b00}
`define AOOT_OFF_OADJ_A_SNGL_A {`AOOT_IDX_OADJ_A_SNGL_A, 2'b00}
`define AOOT_OFF_OADJ_A_SNGL_B {`AOOT_IDX_OADJ_A_SNGL_B, 2'b00}
`define AOOT_OFF_OADJ_B_A {`AOOT_IDX_OADJ_B_A, 2'b00}
`define AOOT_OFF_OADJ_B_B {`AOOT_IDX_OADJ_B_B, 2'b00}
`define AOOT_OFF_OADJ_CTRL {`AOOT_IDX_OADJ_CTRL, 2'b00}
`define AOOT_THR_HI_LSB 0
`define AOOT_THR_LO_LSB 8
`define AOOT_THR_RST 16'h4072
`define AOOT_THR_HI_RST 7'h72
`define AOOT_THR_LO_RST 7'h40
`define AOOT_PLEN_RST 3'h0
`define AOOT_PLEN_BASE 11'h008
`define AOOT_MODE_SINGLE_BIT 0
`define AOOT_MODE_INPUT_BIT 1
`define AOOT_MODE_FGCAL_BIT 2
`define AOOT_OADJ_RST 8'h00
`endif

// ===== aoot_top.v
// Overrange detector and per-core offset trim registers with APB access.
//
// Summary of operation
// - Each magnitude is compared with two thresholds shared by A and B.
// - A signed 8-bit sample becomes a 7-bit magnitude, -128 giving 127.
// - A flag is set to 1 when any checked magnitude reaches its threshold.
// - Channel A and B flags use separate output pairs, index 0 high.
// - A flag holds 8 to 1024 cycles past the last event, set by 3 bits.
// - Samples are two's complement, negative if the minus leg is higher.
// - Dual mode samples on rising edges; single mode on both edges.
// - Core A has a dual and a single trim per input in one range.
// - Core B has one trim per input used in both modes.
`timescale 1ns/1ps
`default_nettype none
`include "aoot_map.vh"
module aoot_top #(
  parameter CNT_W = 11
) (
  input wire pclk, // APB and device clock
  input wire presetn, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error
  input wire [7:0] samp_a_rise, // Core sample, first input, rising edge
  input wire [7:0] samp_a_fall, // Core sample, first input, falling edge
  input wire [7:0] samp_b_rise, // Core sample, second input, rising edge
  input wire [7:0] samp_b_fall, // Core sample, second input, falling edge
  output reg chan_a_flag_high, // Channel A high-threshold overrange
  output reg chan_a_flag_low, // Channel A low-threshold overrange
  output reg chan_b_flag_high, // Channel B high-threshold overrange
  output reg chan_b_flag_low, // Channel B low-threshold overrange
  output reg [7:0] core_a_trim_in_a, // Active core A trim for first input
  output reg [7:0] core_a_trim_in_b, // Active core A trim for second input
  output reg [7:0] core_b_trim_in_a, // Core B trim for first input
  output reg [7:0] core_b_trim_in_b // Core B trim for second input
);
  reg [6:0] overrange_threshold_high;
  reg [6:0] overrange_threshold_low;
  reg [2:0] overrange_pulse_length_sel;
  reg single_mode_r;
  reg single_input_r;
  reg fg_cal_r;
  reg [7:0] core_a_offset_trim_dual [0:1];
  reg [7:0] core_a_offset_trim_single [0:1];
  reg [7:0] core_b_offset_trim [0:1];
  wire [3:0] flag_hold;
  reg pready_r;
  wire [3:0] hit;
  wire [6:0] mag_ar, mag_af, mag_br, mag_bf;
  wire [CNT_W-1:0] plen;
  wire wr_en;
  wire rd_en;
  integer i;

  function [6:0] mag7;
    input [7:0] s;
    reg [7:0] n;
    begin
      n = ~s + 8'h01;
      if (s == 8'h80) begin
        mag7 = 7'h7f;
      end else if (s[7]) begin
        mag7 = n[6:0];
      end else begin
        mag7 = s[6:0];
      end
    end
  endfunction

  function hit2;
    input [6:0] m0;
    input [6:0] m1;
    input use1;
    input [6:0] t;
    begin
      hit2 = (m0 >= t) || (use1 && (m1 >= t));
    end
  endfunction

  // Magnitude conversion of signed codes.
  assign mag_ar = mag7(samp_a_rise);
  assign mag_af = mag7(samp_a_fall);
  assign mag_br = mag7(samp_b_rise);
  assign mag_bf = mag7(samp_b_fall);

  // edge selection
  // In single mode core A gets the chosen input on the rising edge and core B
  // the same input on the falling edge; both fall samples are checked.
  assign hit[0] = hit2(mag_ar, mag_af, single_mode_r,
                       overrange_threshold_high);
  assign hit[1] = hit2(mag_ar, mag_af, single_mode_r,
                       overrange_threshold_low);
  assign hit[2] = hit2(mag_br, mag_bf, single_mode_r,
                       overrange_threshold_high);
  assign hit[3] = hit2(mag_br, mag_bf, single_mode_r,
                       overrange_threshold_low);

  assign plen = `AOOT_PLEN_BASE << overrange_pulse_length_sel;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_flag
      reg [CNT_W-1:0] cnt_r;
      reg flag_r;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r <= {CNT_W{1'b0}};
          flag_r <= 1'b0;
        end else if (hit[g]) begin
          cnt_r <= plen - {{(CNT_W-1){1'b0}}, 1'b1};
          flag_r <= 1'b1;
        end else if (cnt_r != {CNT_W{1'b0}}) begin
          cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end else begin
          flag_r <= 1'b0;
        end
      end
      assign flag_hold[g] = flag_r;
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_a_flag_high <= 1'b0;
      chan_a_flag_low <= 1'b0;
      chan_b_flag_high <= 1'b0;
      chan_b_flag_low <= 1'b0;
    end else begin
      chan_a_flag_high <= flag_hold[0];
      chan_a_flag_low <= flag_hold[1];
      chan_b_flag_high <= flag_hold[2];
      chan_b_flag_low <= flag_hold[3];
    end
  end

  // Ready comes from a flop, so it stays low while reset is held.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
    end
  end

  assign pready = pready_r;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrange_threshold_high <= `AOOT_THR_HI_RST;
      overrange_threshold_low <= `AOOT_THR_LO_RST;
      overrange_pulse_length_sel <= `AOOT_PLEN_RST;
      single_mode_r <= 1'b0;
      single_input_r <= 1'b0;
      fg_cal_r <= 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
        core_a_offset_trim_dual[i] <= `AOOT_OADJ_RST;
        core_a_offset_trim_single[i] <= `AOOT_OADJ_RST;
        core_b_offset_trim[i] <= `AOOT_OADJ_RST;
      end
    end else if (wr_en) begin
      case (paddr)
        `AOOT_OFF_THR: begin
          overrange_threshold_high <=
            pwdata[`AOOT_THR_HI_LSB+6:`AOOT_THR_HI_LSB];
          overrange_threshold_low <=
            pwdata[`AOOT_THR_LO_LSB+6:`AOOT_THR_LO_LSB];
        end
        `AOOT_OFF_PLEN: begin
          overrange_pulse_length_sel <= pwdata[2:0];
        end
        `AOOT_OFF_MODE: begin
          single_mode_r <= pwdata[`AOOT_MODE_SINGLE_BIT];
          single_input_r <= pwdata[`AOOT_MODE_INPUT_BIT];
          fg_cal_r <= pwdata[`AOOT_MODE_FGCAL_BIT];
        end
        `AOOT_OFF_OADJ_A_DUAL_A: core_a_offset_trim_dual[0] <= pwdata[7:0];
        `AOOT_OFF_OADJ_A_DUAL_B: core_a_offset_trim_dual[1] <= pwdata[7:0];
        `AOOT_OFF_OADJ_A_SNGL_A: core_a_offset_trim_single[0] <= pwdata[7:0];
        `AOOT_OFF_OADJ_A_SNGL_B: core_a_offset_trim_single[1] <= pwdata[7:0];
        `AOOT_OFF_OADJ_B_A: core_b_offset_trim[0] <= pwdata[7:0];
        `AOOT_OFF_OADJ_B_B: core_b_offset_trim[1] <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        `AOOT_OFF_THR: prdata <= {17'h0_0000, overrange_threshold_low,
                                  1'b0, overrange_threshold_high};
        `AOOT_OFF_PLEN: prdata <= {29'h0000_0000, overrange_pulse_length_sel};
        `AOOT_OFF_MODE: prdata <= {29'h0000_0000, fg_cal_r, single_input_r,
                                   single_mode_r};
        `AOOT_OFF_STAT: prdata <= {28'h000_0000, flag_hold};
        `AOOT_OFF_OADJ_A_DUAL_A:
          prdata <= {24'h00_0000, core_a_offset_trim_dual[0]};
        `AOOT_OFF_OADJ_A_DUAL_B:
          prdata <= {24'h00_0000, core_a_offset_trim_dual[1]};
        `AOOT_OFF_OADJ_A_SNGL_A:
          prdata <= {24'h00_0000, core_a_offset_trim_single[0]};
        `AOOT_OFF_OADJ_A_SNGL_B:
          prdata <= {24'h00_0000, core_a_offset_trim_single[1]};
        `AOOT_OFF_OADJ_B_A:
          prdata <= {24'h00_0000, core_b_offset_trim[0]};
        `AOOT_OFF_OADJ_B_B:
          prdata <= {24'h00_0000, core_b_offset_trim[1]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_a_trim_in_a <= `AOOT_OADJ_RST;
      core_a_trim_in_b <= `AOOT_OADJ_RST;
      core_b_trim_in_a <= `AOOT_OADJ_RST;
      core_b_trim_in_b <= `AOOT_OADJ_RST;
    end else if (fg_cal_r) begin
      core_a_trim_in_a <= single_mode_r ? core_a_offset_trim_single[0]
                                        : core_a_offset_trim_dual[0];
      core_a_trim_in_b <= single_mode_r ? core_a_offset_trim_single[1]
                                        : core_a_offset_trim_dual[1];
      core_b_trim_in_a <= core_b_offset_trim[0];
      core_b_trim_in_b <= core_b_offset_trim[1];
    end else begin
      core_a_trim_in_a <= `AOOT_OADJ_RST;
      core_a_trim_in_b <= `AOOT_OADJ_RST;
      core_b_trim_in_a <= `AOOT_OADJ_RST;
      core_b_trim_in_b <= `AOOT_OADJ_RST;
    end
  end
endmodule
`default_nettype wire

// ===== aoot_props.sv
// Port assertions for the overrange detector and trim block.
`timescale 1ns/1ps
`default_nettype none
module aoot_props (
  input wire pclk, // Clock
  input wire presetn, // Reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [31:0] prdata, // APB read data
  input wire pready, // APB ready
  input wire pslverr, // APB error
  input wire [7:0] samp_a_rise, // Channel A sample
  input wire [7:0] samp_b_rise, // Channel B sample
  input wire chan_a_flag_high, // Channel A high flag
  input wire chan_a_flag_low, // Channel A low flag
  input wire chan_b_flag_high, // Channel B high flag
  input wire chan_b_flag_low, // Channel B low flag
  input wire [7:0] core_b_trim_in_a // Core B trim output
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A full-scale negative sample reaches every legal threshold.
  sequence a_full;
    samp_a_rise == 8'h80;
  endsequence
  sequence b_full;
    samp_b_rise == 8'h80;
  endsequence
  sequence apb_wr;
    psel && penable && pwrite;
  endsequence
  pready_high_a: assert property ($past(presetn) |-> pready)
    else $error("pready low");
  no_error_a: assert property (!pslverr)
    else $error("pslverr high");
  a_full_hit_a: assert property (a_full |-> ##2
    chan_a_flag_high && chan_a_flag_low)
    else $error("channel A flags missed full scale");
  b_full_hit_a: assert property (b_full |-> ##2
    chan_b_flag_high && chan_b_flag_low)
    else $error("channel B flags missed full scale");
  a_hold_min_a: assert property ($rose(chan_a_flag_high) |->
    chan_a_flag_high[*8])
    else $error("channel A flag too short");
  b_hold_min_a: assert property ($rose(chan_b_flag_low) |->
    chan_b_flag_low[*8])
    else $error("channel B flag too short");
  trim_quiet_a: assert property ($changed(core_b_trim_in_a) |->
    $past(psel && penable && pwrite) ||
    $past(psel && penable && pwrite, 2))
    else $error("trim changed without a write");
  rdata_hold_a: assert property ($changed(prdata) |->
    $past(psel && !penable && !pwrite))
    else $error("read data changed outside a read");
  cover property (apb_wr);
endmodule
bind aoot_top aoot_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .samp_a_rise(samp_a_rise), .samp_b_rise(samp_b_rise),
  .chan_a_flag_high(chan_a_flag_high), .chan_a_flag_low(chan_a_flag_low),
  .chan_b_flag_high(chan_b_flag_high), .chan_b_flag_low(chan_b_flag_low),
  .core_b_trim_in_a(core_b_trim_in_a));
`default_nettype wire

// ===== aoot_mon.sv
// Downstream monitor that merges the overrange outputs per threshold.
`timescale 1ns/1ps
`default_nettype none
module aoot_mon (
  input wire a_high, // Channel A high flag
  input wire a_low, // Channel A low flag
  input wire b_high, // Channel B high flag
  input wire b_low, // Channel B low flag
  output logic or_high, // Merged high status
  output logic or_low // Merged low status
);
  assign or_high = a_high | b_high;
  assign or_low = a_low | b_low;
endmodule
`default_nettype wire

// ===== aoot_top_tb.sv
// Self-checking bench for the overrange detector and trim block.
`timescale 1ns/1ps
`default_nettype none
`include "aoot_map.vh"
module aoot_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, seed = 32'h96eb_fea9, rd;
  logic [7:0] sar = 0, saf = 0, sbr = 0, sbf = 0, v;
  logic [7:0] tv [0:5];
  logic [6:0] hi, lo;
  wire [31:0] prdata;
  wire pready, pslverr, fah, fal, fbh, fbl, or_h, or_l;
  wire [7:0] ta_a, ta_b, tb_a, tb_b;
  integer n_mismatch = 0, cmp_count = 0, i, k;
  always #50 pclk = ~pclk;
  aoot_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .samp_a_rise(sar), .samp_a_fall(saf), .samp_b_rise(sbr),
    .samp_b_fall(sbf), .chan_a_flag_high(fah), .chan_a_flag_low(fal),
    .chan_b_flag_high(fbh), .chan_b_flag_low(fbl), .core_a_trim_in_a(ta_a),
    .core_a_trim_in_b(ta_b), .core_b_trim_in_a(tb_a),
    .core_b_trim_in_b(tb_b));
  aoot_mon mon (.a_high(fah), .a_low(fal), .b_high(fbh), .b_low(fbl),
    .or_high(or_h), .or_low(or_l));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [6:0] mag(input [7:0] s);
    mag = (s == 8'h80) ? 7'h7f : (s[7] ? 7'(~s + 8'h01) : s[6:0]);
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task final_report;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #(100 * 30000);
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, `AOOT_OFF_THR, 0);
    check(rd, `AOOT_THR_RST);
    apb(0, `AOOT_OFF_MODE, 0);
    check(rd, 32'h0000_0004);
    apb(0, 12'h100, 0);
    check(rd, 0);
    for (k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      tv[k] = seed[7:0];
      apb(1, `AOOT_OFF_OADJ_A_DUAL_A + 4 * k, {24'h0, tv[k]});
      apb(0, `AOOT_OFF_OADJ_A_DUAL_A + 4 * k, 0);
      check(rd, {24'h0, tv[k]});
    end
    settle;
    check({ta_a, ta_b, tb_a, tb_b}, {tv[0], tv[1], tv[4], tv[5]});
    apb(1, `AOOT_OFF_MODE, 32'h0000_0005);
    settle;
    check({ta_a, ta_b, tb_a, tb_b}, {tv[2], tv[3], tv[4], tv[5]});
    apb(1, `AOOT_OFF_MODE, 32'h0000_0002);
    apb(0, `AOOT_OFF_MODE, 0);
    check(rd, 32'h0000_0002);
    settle;
    check({ta_a, ta_b, tb_a, tb_b}, 32'h0000_0000);
    apb(1, `AOOT_OFF_MODE, 32'h0000_0004);
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      hi = (i < 2) ? 7'h7f : seed[6:0] | 7'h01;
      lo = (i < 2) ? 7'h40 : seed[14:8] | 7'h01;
      v = (i < 2) ? 8'h80 : seed[23:16];
      apb(1, `AOOT_OFF_THR, {17'h0, lo, 1'b0, hi});
      apb(1, `AOOT_OFF_PLEN, i);
      @(posedge pclk);
      if (i[0]) sbr <= v;
      else sar <= v;
      @(posedge pclk);
      sar <= 0;
      sbr <= 0;
      repeat (2) @(posedge pclk);
      #1;
      k = {mag(v) >= hi, mag(v) >= lo};
      check({fah, fal, fbh, fbl}, i[0] ? k : k << 2);
      // One held cycle has already passed when the flags are first seen.
      k = (k != 0) ? (8 << i) - 1 : 0;
      check(mon.or_high | mon.or_low, k != 0);
      while (fah | fal | fbh | fbl) begin
        @(posedge pclk);
        #1;
        k--;
      end
      check(k, 0);
    end
    apb(1, `AOOT_OFF_MODE, 32'h0000_0005);
    @(posedge pclk);
    sbf <= 8'h80;
    @(posedge pclk);
    sbf <= 0;
    settle;
    check({or_h, or_l}, 2'b11);
    apb(0, `AOOT_OFF_STAT, 0);
    check(rd, 32'h0000_000c);
    repeat (1100) @(posedge pclk);
    apb(1, `AOOT_OFF_MODE, 32'h0000_0004);
    @(posedge pclk);
    saf <= 8'h80;
    @(posedge pclk);
    saf <= 0;
    settle;
    check({or_h, or_l}, 2'b00);
    final_report;
  end
endmodule
`default_nettype wire
